/* File: lsc_pkg.sv */
// lsc_pkg: constants, types and helpers of the output scaling block
// assumes a 125 MHz system clock and registers reached over wishbone
`default_nettype none
package lsc_pkg;
    // datapath widths
    localparam int DW = 32;       // detector value width
    localparam int FW = 16;       // fraction bits of scaled values
    localparam int QW = 21;       // quotient bits, 5 integer + 16 fraction
    localparam int BW = DW + QW;  // divider working width
    localparam int CW = 16;       // converter code width
    localparam int NCH = 3;       // scaled channels
    localparam int CH_X = 0;      // in-phase channel
    localparam int CH_Y = 1;      // quadrature channel
    localparam int CH_R = 2;      // magnitude channel
    localparam int CNT_W = 5;     // divider step counter width

    // output update rate, fractional tick accumulator
    localparam int CLK_KHZ = 125000;
    localparam int OUT_RATE_KHZ = 2000;
    localparam int RATE_MOD = 250;
    localparam logic [7:0] RATE_MOD_C = 8'(RATE_MOD);
    localparam logic [7:0] RATE_STEP = 8'(OUT_RATE_KHZ * RATE_MOD / CLK_KHZ);

    // scales
    localparam logic signed [CW-1:0] FS_CODE = 16'sh7FFF;  // 10 V code
    localparam logic signed [QW:0] ONE_Q = 22'sh01_0000;   // 1.0 in q16
    localparam logic [15:0] AUX_ONE_V = 16'h03E8;          // 1.000 V in mV
    localparam logic [15:0] PHASE_FS = 16'h4650;           // 180 deg, 0.01
    localparam logic [16:0] PHASE_K =
        17'((32'(FS_CODE) << FW) / 32'(PHASE_FS));
    localparam logic signed [DW-1:0] OFF_MAX = 32'sh0001_863C; // 999.00 %
    localparam logic [19:0] OFF_K = 20'h6_8DB9;  // q32 of 1/10000, the fraction of one 0.01 % step
    localparam logic [7:0] EXP_F1 = 8'h01;
    localparam logic [7:0] EXP_F10 = 8'h0A;
    localparam logic [7:0] EXP_F100 = 8'h64;

    // register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_SENS = 8'h04;
    localparam logic [7:0] REG_OFF0 = 8'h08;  // x, then y, then r
    localparam logic [7:0] REG_RCFG = 8'h14;
    localparam logic [7:0] REG_STAT = 8'h18;
    localparam logic [7:0] REG_MASK = 8'h1C;
    localparam logic [7:0] REG_LIVE = 8'h20;
    localparam logic [7:0] REG_STEP = 8'h04;
    // fields
    localparam int CTRL_F1_SEL = 0;    // front one: 0 in-phase, 1 magnitude
    localparam int CTRL_F2_SEL = 1;    // front two: 0 quadrature, 1 phase
    localparam int RCFG_EXP_LSB = 4;   // two expand bits per channel
    localparam int ST_SYNC = 3;        // status: sync filter overflow
    localparam int NST = 4;            // status width
    localparam logic [31:0] SENS_RST = 32'h0001_0000;

    typedef enum logic [1:0] {
        LSC_EXP_X1 = 2'b00,
        LSC_EXP_X10 = 2'b01,
        LSC_EXP_X100 = 2'b10
    } lsc_exp_t;

    typedef enum logic [1:0] {
        LSC_IDLE = 2'b00,
        LSC_NORM = 2'b01,
        LSC_RATIO = 2'b10
    } lsc_state_t;

    // one detector sample set
    typedef struct packed {
        logic signed [DW-1:0] x;
        logic signed [DW-1:0] y;
        logic signed [DW-1:0] r;
        logic signed [15:0] theta;  // 0.01 deg units
        logic signed [15:0] aux3;   // mV
        logic signed [15:0] aux4;   // mV
    } lsc_det_t;

    // display view of one channel
    typedef struct packed {
        logic signed [QW:0] disp;   // offset and ratio, pinned at 1.0
        logic signed [QW:0] chart;  // offset and ratio, not expanded
        logic signed [CW-1:0] bar;  // expanded, as the connector
        logic off_ind;
        logic ratio_ind;
        logic exp_ind;
    } lsc_view_t;

    // byte-lane merge of a write into a register
    function automatic logic [31:0] lsc_merge(input logic [31:0] old,
            input logic [31:0] dat, input logic [3:0] sel);
        logic [31:0] m;
        m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
        return (old & ~m) | (dat & m);
    endfunction
endpackage
`default_nettype wire

/* File: lsc_output_scaling.sv */
// lsc_output_scaling: output scaling datapath of a lock-in instrument
// assumes detector values in input lsb units, aux inputs in mV, theta in
// 0.01 deg, all synchronous to mclk_in; registers over classic wishbone
//
// Contract
// RULE1 - new rear outputs at 2.0 MHz
// RULE2 - front one x or r, two y or phase
// RULE3 - front copies rear when x or y selected
// RULE4 - sensitivity maps to 10 V, x y bipolar
// RULE5 - overload flags and pins output, measurement untouched
// RULE6 - phase at 18 degrees per volt
// RULE7 - offset kept as percent, up to 999
// RULE8 - ratio divides by aux over 1 V
// RULE9 - expand 1, 10 or 100, clamp 10 V
// RULE10 - sensitivity, offset, ratio, expand, full scale order
// RULE11 - each channel own settings, phase none
// RULE12 - displays carry offset and ratio indicators
// RULE13 - display not expanded, expand indicator
// RULE14 - bar expanded, chart offset only; chart here also carries ratio
// RULE15 - ratio status lamp when any ratio on
// RULE16 - sync conversion overflow raises error flag
// RULE17 - one sample set per update, fixed latency
//
// The Wishbone slave port and the address map were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module lsc_output_scaling (
    input wire logic mclk_in,
    input wire logic rstn_in,
    input wire logic ce_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [7:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    input wire lsc_pkg::lsc_det_t det_in,
    output logic det_take_out,
    output logic signed [lsc_pkg::CW-1:0] rear_x_out,
    output logic signed [lsc_pkg::CW-1:0] rear_y_out,
    output logic signed [lsc_pkg::CW-1:0] front_output_one_out,
    output logic signed [lsc_pkg::CW-1:0] front_output_two_out,
    output lsc_pkg::lsc_view_t [lsc_pkg::NCH-1:0] views_out,
    output logic ratio_led_out,
    output logic irq_out
);
    import lsc_pkg::*;

    // register state
    logic [1:0] ctrl_q;                 // front selections
    logic [31:0] sens_q;                // sensitivity, input lsb units
    logic signed [DW-1:0] off_q [NCH];  // offsets, 0.01 % units
    logic [31:0] rcfg_q;                // ratio enables and expands
    logic [NST-1:0] stat_q;             // sticky events
    logic [NST-1:0] mask_q;             // interrupt mask
    logic ack_q;
    logic [31:0] rdat_q;

    // rate generator
    logic [7:0] acc_q;
    logic tick_q;

    // per channel results
    logic signed [CW-1:0] code_q [NCH];
    logic signed [QW:0] rq_q [NCH];
    logic ovl_q [NCH];
    logic sync_ev [NCH];
    logic idle_w [NCH];

    // phase path, latched with the sample set
    logic signed [15:0] theta_q;
    logic signed [15:0] aux3_q;
    logic signed [15:0] aux4_q;
    logic signed [32:0] ph_prod;
    logic signed [CW-1:0] ph_code;
    logic signed [CW-1:0] ph_code_q;

    // bus decode
    wire acc_w = wb_cyc_in & wb_stb_in;
    wire wr_w = acc_w & wb_we_in & ack_q;
    wire [31:0] bmask = {{8{wb_sel_in[3]}}, {8{wb_sel_in[2]}},
        {8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};
    wire [31:0] stat_ext = 32'(stat_q);
    wire [NST-1:0] w1c_w = (wr_w && wb_adr_in == REG_STAT) ?
        NST'(wb_dat_in & bmask) : '0;
    wire ratio_any = |rcfg_q[NCH-1:0];
    wire [NST-1:0] ev_w;

    // read selection, unmapped reads as zero
    wire [31:0] rd_w =
        (wb_adr_in == REG_CTRL) ? 32'(ctrl_q) :
        (wb_adr_in == REG_SENS) ? sens_q :
        (wb_adr_in == REG_OFF0) ? off_q[CH_X] :
        (wb_adr_in == REG_OFF0 + REG_STEP) ? off_q[CH_Y] :
        (wb_adr_in == REG_OFF0 + 2 * REG_STEP) ? off_q[CH_R] :
        (wb_adr_in == REG_RCFG) ? rcfg_q :
        (wb_adr_in == REG_STAT) ? stat_ext :
        (wb_adr_in == REG_MASK) ? 32'(mask_q) :
        (wb_adr_in == REG_LIVE) ? {30'h0, ratio_any, irq_out} : '0;

    // bus handshake: ack one cycle after the request, dropped next cycle
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ack_q <= 1'b0;
            rdat_q <= '0;
        end else if (ce_in) begin
            ack_q <= acc_w & ~ack_q;
            rdat_q <= rd_w;
        end
    end
    assign wb_ack_out = ack_q;
    assign wb_dat_out = rdat_q;

    // control registers, written on the acknowledged edge
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ctrl_q <= '0;
            sens_q <= SENS_RST;
            rcfg_q <= '0;
            mask_q <= '0;
        end else if (ce_in && wr_w) begin
            if (wb_adr_in == REG_CTRL) ctrl_q <= 2'(lsc_merge(32'(ctrl_q),
                wb_dat_in, wb_sel_in));
            if (wb_adr_in == REG_SENS) sens_q <= lsc_merge(sens_q,
                wb_dat_in, wb_sel_in);
            if (wb_adr_in == REG_RCFG) rcfg_q <= lsc_merge(rcfg_q,
                wb_dat_in, wb_sel_in);
            if (wb_adr_in == REG_MASK) mask_q <= NST'(lsc_merge(
                32'(mask_q), wb_dat_in, wb_sel_in));
        end
    end

    // sticky status: a new event wins over a clear in the same cycle
    assign ev_w = {sync_ev[CH_X] | sync_ev[CH_Y] | sync_ev[CH_R],
        tick_q & ovl_q[CH_R], tick_q & ovl_q[CH_Y], tick_q & ovl_q[CH_X]};
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            stat_q <= '0;
            irq_out <= 1'b0;
            ratio_led_out <= 1'b0;
        end else if (ce_in) begin
            stat_q <= (stat_q & ~w1c_w) | ev_w;  // RULE5 RULE16
            irq_out <= |(stat_q & mask_q);
            ratio_led_out <= ratio_any;          // RULE15
        end
    end

    // fractional accumulator: exactly 2.0 MHz on average
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            acc_q <= '0;
            tick_q <= 1'b0;
            ph_code_q <= '0;
        end else if (ce_in) begin
            acc_q <= (acc_q + RATE_STEP >= RATE_MOD_C) ?
                acc_q + RATE_STEP - RATE_MOD_C : acc_q + RATE_STEP; // RULE1
            tick_q <= (acc_q + RATE_STEP >= RATE_MOD_C);
            ph_code_q <= ph_code;  // follows theta_q, same latency as x
        end
    end
    assign det_take_out = tick_q;  // sample set taken on this cycle

    // phase: 180 deg gives full scale, no sensitivity involved
    assign ph_prod = theta_q * $signed({1'b0, PHASE_K});        // RULE6
    assign ph_code = ($signed(ph_prod[32:FW]) > 17'(FS_CODE)) ? FS_CODE :
        ($signed(ph_prod[32:FW]) < -17'(FS_CODE)) ? -FS_CODE :
        ph_prod[FW+CW-1:FW];

    // capture raw phase and aux inputs with the sample set
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            theta_q <= '0;
            aux3_q <= '0;
            aux4_q <= '0;
        end else if (ce_in && tick_q) begin
            theta_q <= det_in.theta;
            aux3_q <= det_in.aux3;
            aux4_q <= det_in.aux4;
        end
    end

    // one divider per channel, reused for sensitivity then ratio
    for (genvar ch = 0; ch < NCH; ch++) begin : g_ch
        lsc_state_t st_q;
        logic [BW-1:0] rem_q;
        logic [BW-1:0] d_q;
        logic [QW-1:0] q_q;
        logic [CNT_W-1:0] cnt_q;
        logic neg_q;
        logic ovf_q;
        logic signed [DW-1:0] off_w;
        logic signed [DW-1:0] v_w;
        logic signed [15:0] aux_w;
        logic [DW-1:0] vmag;
        logic [15:0] amag;
        logic signed [52:0] offp;
        logic signed [QW:0] off_fr;
        logic signed [QW:0] res_w;
        logic signed [QW+1:0] diff_w;
        logic [QW+1:0] dmag;
        logic [BW-1:0] la_w;
        logic [BW-1:0] lb_w;
        logic ovf_w;
        logic [7:0] fac_w;
        logic signed [QW+8:0] exp_w;
        logic signed [QW+24:0] prod_w;
        logic ovl_w;
        lsc_exp_t exp_sel;

        // offset register, clipped to the programmable span
        wire [7:0] off_adr = REG_OFF0 + 8'(ch) * REG_STEP;
        wire signed [DW-1:0] off_m = lsc_merge(off_q[ch], wb_dat_in,
            wb_sel_in);
        assign off_w = (off_m > OFF_MAX) ? OFF_MAX :
            (off_m < -OFF_MAX) ? -OFF_MAX : off_m;
        always_ff @(posedge mclk_in or negedge rstn_in) begin
            if (!rstn_in) off_q[ch] <= '0;
            else if (ce_in && wr_w && wb_adr_in == off_adr)
                off_q[ch] <= off_w;                             // RULE7
        end

        // own source per channel, ratio input aux3 for x and y, aux4 for r
        assign v_w = (ch == CH_X) ? det_in.x :
            (ch == CH_Y) ? det_in.y : det_in.r;                 // RULE11
        assign aux_w = !rcfg_q[ch] ? $signed(AUX_ONE_V) :
            (ch == CH_R) ? aux4_q : aux3_q;                     // RULE8
        assign vmag = v_w[DW-1] ? DW'(-v_w) : DW'(v_w);
        assign amag = aux_w[15] ? 16'(-aux_w) : 16'(aux_w);
        assign exp_sel = lsc_exp_t'(rcfg_q[RCFG_EXP_LSB+2*ch +: 2]);

        // signed quotient, saturated on overflow
        assign res_w = ovf_q ? (neg_q ? -$signed({1'b0, {QW{1'b1}}}) :
            $signed({1'b0, {QW{1'b1}}})) :
            (neg_q ? -$signed({1'b0, q_q}) : $signed({1'b0, q_q}));
        // offset percent to fraction of the sensitivity
        assign offp = off_q[ch] * $signed({1'b0, OFF_K});
        assign off_fr = offp[FW+QW:FW];
        assign diff_w = res_w - off_fr;                         // RULE10
        assign dmag = diff_w[QW+1] ? (QW+2)'(-diff_w) : (QW+2)'(diff_w);

        // dividend and divisor of the next division
        assign la_w = (st_q == LSC_IDLE) ? BW'(vmag) << FW :
            BW'(dmag) * BW'(AUX_ONE_V);
        assign lb_w = (st_q == LSC_IDLE) ? BW'(sens_q) : BW'(amag);
        assign ovf_w = (lb_w == '0) || (la_w >= (lb_w << QW));

        // expand and full-scale conversion
        always_comb begin
            unique case (exp_sel)
                LSC_EXP_X10: fac_w = EXP_F10;
                LSC_EXP_X100: fac_w = EXP_F100;
                default: fac_w = EXP_F1;  // code 2'b11 acts as one
            endcase
        end
        assign exp_w = res_w * $signed({1'b0, fac_w});          // RULE9
        assign ovl_w = (exp_w > ONE_Q) || (exp_w < -ONE_Q);     // RULE5
        assign prod_w = exp_w * FS_CODE;                        // RULE4
        assign idle_w[ch] = (st_q == LSC_IDLE);

        // sequencer: start on tick, normalise, divide by ratio, scale
        always_ff @(posedge mclk_in or negedge rstn_in) begin
            if (!rstn_in) begin
                st_q <= LSC_IDLE;
                rem_q <= '0;
                d_q <= '0;
                q_q <= '0;
                cnt_q <= '0;
                neg_q <= 1'b0;
                ovf_q <= 1'b0;
                sync_ev[ch] <= 1'b0;
                code_q[ch] <= '0;
                rq_q[ch] <= '0;
                ovl_q[ch] <= 1'b0;
            end else if (ce_in) begin
                sync_ev[ch] <= 1'b0;
                if (st_q != LSC_IDLE && cnt_q != '0) begin
                    // one restoring step per cycle
                    rem_q <= (rem_q >= d_q) ? rem_q - d_q : rem_q;
                    q_q <= {q_q[QW-2:0], rem_q >= d_q};
                    d_q <= d_q >> 1;
                    cnt_q <= cnt_q - 1'b1;
                end else begin
                    unique case (st_q)
                        LSC_IDLE: if (tick_q) begin            // RULE17
                            rem_q <= la_w;
                            d_q <= lb_w << (QW - 1);
                            ovf_q <= ovf_w;
                            neg_q <= v_w[DW-1];
                            q_q <= '0;
                            cnt_q <= CNT_W'(QW);
                            st_q <= LSC_NORM;
                        end
                        LSC_NORM: begin
                            sync_ev[ch] <= ovf_q;               // RULE16
                            rem_q <= la_w;
                            d_q <= lb_w << (QW - 1);
                            ovf_q <= ovf_w;
                            neg_q <= diff_w[QW+1] ^ aux_w[15];
                            q_q <= '0;
                            cnt_q <= CNT_W'(QW);
                            st_q <= LSC_RATIO;
                        end
                        LSC_RATIO: begin
                            rq_q[ch] <= res_w;                  // RULE14
                            ovl_q[ch] <= ovl_w;
                            code_q[ch] <= ovl_w ? (exp_w[QW+8] ?
                                -FS_CODE : FS_CODE) :
                                prod_w[FW+CW-1:FW];             // RULE9
                            st_q <= LSC_IDLE;
                        end
                        default: st_q <= LSC_IDLE;
                    endcase
                end
            end
        end

        // the next tick finds the channel finished
        a_chan_done: assert property (@(posedge mclk_in) disable iff  // RULE17
            (!rstn_in) tick_q |-> idle_w[ch])
            else $error("channel still busy at update");
        a_sync_flag: assert property (@(posedge mclk_in) disable iff  // RULE16
            (!rstn_in) (ce_in && sync_ev[ch]) |=> stat_q[ST_SYNC])
            else $error("sync overflow not flagged");
        a_ovl_pinned: assert property (@(posedge mclk_in) disable iff  // RULE5
            (!rstn_in) ovl_q[ch] |-> (code_q[ch] == FS_CODE ||
            code_q[ch] == -FS_CODE))
            else $error("overload code not pinned");
    end

    // publish at the update tick: one update period of latency
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rear_x_out <= '0;
            rear_y_out <= '0;
            front_output_one_out <= '0;
            front_output_two_out <= '0;
            views_out <= '0;
        end else if (ce_in && tick_q) begin
            rear_x_out <= code_q[CH_X];                         // RULE1
            rear_y_out <= code_q[CH_Y];
            front_output_one_out <= ctrl_q[CTRL_F1_SEL] ?
                code_q[CH_R] : code_q[CH_X];                    // RULE2 RULE3
            front_output_two_out <= ctrl_q[CTRL_F2_SEL] ?
                ph_code_q : code_q[CH_Y];                       // RULE2 RULE6
            for (int c = 0; c < NCH; c++) begin
                views_out[c].disp <= (rq_q[c] > ONE_Q) ? ONE_Q :
                    (rq_q[c] < -ONE_Q) ? -ONE_Q : rq_q[c];      // RULE13
                views_out[c].chart <= rq_q[c];                  // RULE14
                views_out[c].bar <= code_q[c];                  // RULE14
                views_out[c].off_ind <= off_q[c] != '0;         // RULE12
                views_out[c].ratio_ind <= rcfg_q[c];            // RULE12
                views_out[c].exp_ind <=
                    rcfg_q[RCFG_EXP_LSB+2*c +: 2] != '0;        // RULE13
            end
        end
    end

    // helper: cycles since the previous tick
    logic [7:0] gap_q;
    logic seen_q;
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            gap_q <= '0;
            seen_q <= 1'b0;
        end else if (ce_in) begin
            gap_q <= tick_q ? '0 : gap_q + 1'b1;
            seen_q <= seen_q | tick_q;
        end
    end

    a_tick_rate: assert property (@(posedge mclk_in) disable iff  // RULE1
        (!rstn_in) (tick_q && seen_q) |-> (gap_q == 8'h3D ||
        gap_q == 8'h3E))
        else $error("update spacing not 62 or 63 cycles");
    a_front_copy: assert property (@(posedge mclk_in) disable iff  // RULE3
        (!rstn_in) (ce_in && tick_q && !ctrl_q[CTRL_F1_SEL]) |=>
        front_output_one_out == rear_x_out)
        else $error("front one differs from rear x");
    a_front_phase: assert property (@(posedge mclk_in) disable iff  // RULE6
        (!rstn_in) (ce_in && tick_q && ctrl_q[CTRL_F2_SEL]) |=>
        front_output_two_out == $past(ph_code_q))
        else $error("front two does not carry phase");
    a_out_span: assert property (@(posedge mclk_in) disable iff  // RULE9
        (!rstn_in) rear_y_out <= FS_CODE && rear_y_out >= -FS_CODE)
        else $error("rear y beyond full scale");
    a_ratio_lamp: assert property (@(posedge mclk_in) disable iff  // RULE15
        (!rstn_in) ce_in ##1 ce_in |-> ratio_led_out == $past(ratio_any))
        else $error("ratio lamp wrong");
    a_irq_level: assert property (@(posedge mclk_in) disable iff
        (!rstn_in) (ce_in && (stat_q & mask_q) != '0) |=> irq_out)
        else $error("irq not raised for unmasked event");

    c_overload: cover property (@(posedge mclk_in) tick_q && ovl_q[CH_X]);
    c_ratio: cover property (@(posedge mclk_in) tick_q && ratio_any);
    c_phase: cover property (@(posedge mclk_in)
        tick_q && ctrl_q[CTRL_F2_SEL]);
    c_sync: cover property (@(posedge mclk_in) sync_ev[CH_R]);
endmodule
`default_nettype wire

/* File: lsc_dac_model.sv */
// lsc_dac_model: four output converters at the far side of the block
// assumes codes are steady between publishes, sampled on mclk_in
`timescale 1ns/10ps
`default_nettype none
module lsc_dac_model
    import lsc_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rstn_in,
    input wire logic [3:0][CW-1:0] code_in,
    output logic [15:0] updates_out
);
    // last code each converter holds, in code units
    logic [3:0][CW-1:0] held_q;
    // latch codes and count the cycles in which any converter's code changes
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            held_q <= '0;
            updates_out <= 16'h0000;
        end else if (code_in != held_q) begin
            held_q <= code_in;
            updates_out <= updates_out + 16'h0001;
        end
    end
endmodule
`default_nettype wire

/* File: lsc_output_scaling_tb_top.sv */
// lsc_output_scaling_tb_top: register and datapath tests of the scaler
// assumes one 125 MHz clock and a classic wishbone register bus
`timescale 1ns/10ps
`default_nettype none
module lsc_output_scaling_tb_top;
    import lsc_pkg::*;
    logic mclk_in = 1'b0, rstn_in = 1'b0, cyc = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0000_0000, rdat, d;
    logic ack, take, led, irq;
    lsc_det_t det = '0;
    logic signed [CW-1:0] rx, ry, f1, f2;
    lsc_view_t [NCH-1:0] v;
    logic [15:0] upd;
    int n_mismatch = 0, n_checks = 0;
    always #4 mclk_in = ~mclk_in;
    lsc_output_scaling i_lsc_output_scaling (.mclk_in(mclk_in),
        .rstn_in(rstn_in), .ce_in(1'b1), .wb_cyc_in(cyc), .wb_stb_in(cyc),
        .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hF), .wb_dat_in(wdat),
        .wb_dat_out(rdat), .wb_ack_out(ack), .det_in(det),
        .det_take_out(take), .rear_x_out(rx), .rear_y_out(ry),
        .front_output_one_out(f1), .front_output_two_out(f2),
        .views_out(v), .ratio_led_out(led), .irq_out(irq));
    lsc_dac_model i_lsc_dac_model (.mclk_in(mclk_in), .rstn_in(rstn_in),
        .code_in({rx, ry, f1, f2}), .updates_out(upd));
    // compare one value and count it
    task automatic chk(input string nm, input logic [31:0] s, e);
        n_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask
    // one classic cycle, held until ack is sampled high
    task automatic bus(input logic w, input logic [7:0] a,
            input logic [31:0] wd);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= wd;
        @(posedge mclk_in);
        while (ack !== 1'b1) @(posedge mclk_in);
        d = rdat;
        cyc <= 1'b0;
        we <= 1'b0;
        @(posedge mclk_in);
    endtask
    // wait for n update ticks, then let the publish land
    task automatic pubs(input int n);
        repeat (n) begin
            @(posedge mclk_in);
            while (take !== 1'b1) @(posedge mclk_in);
        end
        repeat (3) @(posedge mclk_in);
    endtask
    // verdict and end of run
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // watchdog well beyond the expected run of some 800 cycles
    initial begin
        #200000;
        n_mismatch++;
        summarize();
    end
    initial begin
        repeat (12) @(posedge mclk_in);
        rstn_in <= 1'b1;
        @(posedge mclk_in);
        bus(1'b0, REG_SENS, 32'h0000_0000);
        chk("sens", d, 32'h0001_0000);
        bus(1'b0, 8'h30, 32'h0000_0000);
        chk("unmapped", d, 32'h0000_0000);
        // half scale in-phase, negative half quadrature, twice scale r
        det <= '{x: 32'h0000_8000, y: 32'hFFFF_8000, r: 32'h0002_0000,
            theta: 16'h2328, aux3: 16'h07D0, aux4: 16'h03E8};
        pubs(3);
        chk("rear_x", 32'(rx), 32'h0000_3FFF);
        chk("rear_y", 32'(ry), 32'hFFFF_C000);
        chk("front1", 32'(f1), 32'h0000_3FFF);
        chk("front2", 32'(f2), 32'hFFFF_C000);
        chk("dac", 32'(upd != 16'h0000), 32'h0000_0001);
        bus(1'b1, REG_CTRL, 32'h0000_0003);
        pubs(2);
        chk("front1_r", 32'(f1), 32'h0000_7FFF);
        chk("front2_ph", 32'(f2), 32'h0000_3FFF);
        chk("disp_r", 32'(v[2].disp), 32'h0001_0000);
        chk("chart_r", 32'(v[2].chart), 32'h0002_0000);
        bus(1'b0, REG_STAT, 32'h0000_0000);
        chk("ovl_r", d & 32'h0000_0004, 32'h0000_0004);
        // offset 45 % and expand ten on x, ratio by two volts on y
        bus(1'b1, REG_OFF0, 32'h0000_1194);
        bus(1'b1, REG_RCFG, 32'h0000_0012);
        pubs(2);
        chk("rear_x_exp", 32'(rx), 32'h0000_4000);
        chk("bar_x", 32'(v[0].bar), 32'h0000_4000);
        chk("disp_x", 32'(v[0].disp), 32'h0000_0CCD);
        chk("exp_ind", 32'(v[0].exp_ind), 32'h0000_0001);
        chk("off_ind", 32'(v[0].off_ind), 32'h0000_0001);
        chk("rear_y_rat", 32'(ry), 32'hFFFF_E000);
        chk("rat_ind", 32'(v[1].ratio_ind), 32'h0000_0001);
        chk("ratio_led", 32'(led), 32'h0000_0001);
        chk("front1_r2", 32'(f1), 32'h0000_7FFF);
        // unmasked overload raises the line, clearing drops it
        bus(1'b1, REG_MASK, 32'h0000_0004);
        repeat (2) @(posedge mclk_in);
        chk("irq_on", 32'(irq), 32'h0000_0001);
        // ratio on r by one volt, expand hundred on y, negative phase
        bus(1'b1, REG_RCFG, 32'h0000_0096);
        det.r <= 32'h0000_8000;
        det.theta <= 16'hDCD8;
        pubs(3);
        chk("front1_rat", 32'(f1), 32'h0000_3FFF);
        chk("rear_y_x100", 32'(ry), 32'hFFFF_8001);
        chk("front2_neg", 32'(f2), 32'hFFFF_C000);
        bus(1'b1, REG_STAT, 32'h0000_000F);
        repeat (2) @(posedge mclk_in);
        chk("irq_off", 32'(irq), 32'h0000_0000);
        // in-phase beyond the integer range of the sync conversion
        det.x <= 32'h7FFF_FFFF;
        pubs(3);
        bus(1'b0, REG_STAT, 32'h0000_0000);
        chk("sync_err", d & 32'h0000_0008, 32'h0000_0008);
        summarize();
    end
endmodule
`default_nettype wire
